// ===== pkg/pia_pkg.sv
package pia_pkg;

  // Vector space and register bus shape
  localparam int PIA_NUM_VEC = 64;
  localparam int PIA_VEC_W = 6;
  localparam int PIA_NUM_PINS = 6;
  localparam int PIA_ADDR_W = 4;
  localparam int PIA_DATA_W = 8;
  localparam int PIA_NUM_EN_BYTES = PIA_NUM_VEC / PIA_DATA_W;

  typedef logic [PIA_VEC_W-1:0] pia_vec_t;
  typedef logic [PIA_ADDR_W-1:0] pia_addr_t;
  typedef logic [PIA_DATA_W-1:0] pia_data_t;

  // Fixed vector numbers
  localparam pia_vec_t PIA_VEC_NMI = 6'h07;
  localparam pia_vec_t PIA_VEC_PIN0 = 6'h0C;
  localparam pia_vec_t PIA_VEC_PIN5 = 6'h11;
  localparam pia_vec_t PIA_VEC_WDOG = 6'h14;
  localparam pia_vec_t PIA_VEC_ADC = 6'h17;
  localparam pia_vec_t PIA_VEC_T16C0_LO = 6'h18;
  localparam pia_vec_t PIA_VEC_T16C0_HI = 6'h1A;
  localparam pia_vec_t PIA_VEC_T16C1_LO = 6'h1C;
  localparam pia_vec_t PIA_VEC_T16C1_HI = 6'h1E;
  localparam pia_vec_t PIA_VEC_T16C2_LO = 6'h20;
  localparam pia_vec_t PIA_VEC_T16C2_HI = 6'h22;
  localparam pia_vec_t PIA_VEC_T8C01_LO = 6'h24;
  localparam pia_vec_t PIA_VEC_T8C01_HI = 6'h27;
  localparam pia_vec_t PIA_VEC_T8C23_LO = 6'h28;
  localparam pia_vec_t PIA_VEC_T8C23_HI = 6'h2B;
  // Serial unit 0: rx error, rx full, tx empty, tx end in that order
  localparam pia_vec_t PIA_VEC_SERIAL0_LO = 6'h34;
  localparam pia_vec_t PIA_VEC_SERIAL0_HI = 6'h37;
  localparam pia_vec_t PIA_VEC_SERIAL1_LO = 6'h38;
  localparam pia_vec_t PIA_VEC_SERIAL1_HI = 6'h3B;

  // Vectors that carry a maskable source; all others are reserved or NMI
  localparam logic [PIA_NUM_VEC-1:0] PIA_SRC_MASK = 64'h0FF0_0FF7_7793_F000;

  // Bit positions of the group level bits in the two level registers
  localparam int PIA_LA_PIN0 = 7;
  localparam int PIA_LA_PIN1 = 6;
  localparam int PIA_LA_PIN23 = 5;
  localparam int PIA_LA_PIN45 = 4;
  localparam int PIA_LA_WDOG = 3;
  localparam int PIA_LA_T16C0 = 2;
  localparam int PIA_LA_T16C1 = 1;
  localparam int PIA_LA_T16C2 = 0;
  localparam int PIA_LB_T8C01 = 7;
  localparam int PIA_LB_T8C23 = 6;
  localparam int PIA_LB_SERIAL0 = 3;
  localparam int PIA_LB_SERIAL1 = 2;

  // Register map
  localparam pia_addr_t PIA_OFF_SYSCTL = 4'h0;
  localparam pia_addr_t PIA_OFF_LEVEL_A = 4'h1;
  localparam pia_addr_t PIA_OFF_LEVEL_B = 4'h2;
  localparam pia_addr_t PIA_OFF_EN0 = 4'h3;
  localparam pia_addr_t PIA_OFF_STATUS = 4'hB;
  localparam pia_addr_t PIA_OFF_STATE = 4'hC;

  localparam int PIA_SYS_MODE_BIT = 0;
  localparam int PIA_SYS_ADV_BIT = 1;
  localparam pia_data_t PIA_SYSCTL_RST = 8'h03;
  localparam pia_data_t PIA_LEVEL_RST = 8'h00;
  localparam pia_data_t PIA_EN_RST = 8'h00;
  localparam int PIA_STAT_VALID_BIT = 7;
  localparam int PIA_STATE_NMI_BIT = 0;
  localparam int PIA_STATE_STBY_BIT = 1;
  localparam int PIA_STATE_SEL_BIT = 2;

  // Vector table entry size as a shift: four bytes advanced, two normal
  localparam int PIA_ADV_SHIFT = 2;
  localparam int PIA_NORM_SHIFT = 1;

  typedef struct packed {
    logic mask_global;
    logic user_mask_bit;
    logic accept;
  } pia_cpu_t;

  typedef struct packed {
    logic valid;
    pia_vec_t vector;
    logic [15:0] addr;
  } pia_req_t;

  function automatic logic pia_level_of(input pia_vec_t v, input pia_data_t la, input pia_data_t lb);
    logic lvl;
    lvl = 1'b0;
    if (v == PIA_VEC_PIN0) lvl = la[PIA_LA_PIN0];
    else if (v == PIA_VEC_PIN0 + 6'h01) lvl = la[PIA_LA_PIN1];
    else if (v inside {[PIA_VEC_PIN0 + 6'h02 : PIA_VEC_PIN0 + 6'h03]}) lvl = la[PIA_LA_PIN23];
    else if (v inside {[PIA_VEC_PIN0 + 6'h04 : PIA_VEC_PIN5]}) lvl = la[PIA_LA_PIN45];
    else if (v == PIA_VEC_WDOG) lvl = la[PIA_LA_WDOG];
    else if (v inside {[PIA_VEC_T16C0_LO : PIA_VEC_T16C0_HI]}) lvl = la[PIA_LA_T16C0];
    else if (v inside {[PIA_VEC_T16C1_LO : PIA_VEC_T16C1_HI]}) lvl = la[PIA_LA_T16C1];
    else if (v inside {[PIA_VEC_T16C2_LO : PIA_VEC_T16C2_HI]}) lvl = la[PIA_LA_T16C2];
    else if (v inside {[PIA_VEC_T8C01_LO : PIA_VEC_T8C01_HI]}) lvl = lb[PIA_LB_T8C01];
    else if (v inside {[PIA_VEC_T8C23_LO : PIA_VEC_T8C23_HI]}) lvl = lb[PIA_LB_T8C23];
    else if (v inside {[PIA_VEC_SERIAL0_LO : PIA_VEC_SERIAL0_HI]}) lvl = lb[PIA_LB_SERIAL0];
    else if (v inside {[PIA_VEC_SERIAL1_LO : PIA_VEC_SERIAL1_HI]}) lvl = lb[PIA_LB_SERIAL1];
    return lvl;
  endfunction

endpackage

// ===== rtl/pia_sync.sv
`timescale 1ns/1ps
// Three-stage input synchroniser; the output follows once stages two and three agree
module pia_sync #(
  parameter int WIDTH = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= {WIDTH{RST_VAL}};
      s2_q <= {WIDTH{RST_VAL}};
      s3_q <= {WIDTH{RST_VAL}};
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit: a single-cycle glitch past stage two never reaches the output
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lvl_q <= {WIDTH{RST_VAL}};
    end else begin
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  assign o_level = lvl_q;

endmodule

// ===== rtl/pia_pick.sv
`timescale 1ns/1ps
// Finds the lowest set index among the candidates
module pia_pick #(
  parameter int N = 64,
  parameter int W = 6
) (
  input wire logic [N-1:0] i_cand,
  output logic o_found,
  output logic [W-1:0] o_index
);

  logic [N:0] below;
  logic [N-1:0] first;

  assign below[0] = 1'b0;

  generate
    for (genvar i = 0; i < N; i++) begin : g_bit
      assign below[i+1] = below[i] | i_cand[i];
      assign first[i] = i_cand[i] & ~below[i];
    end
  endgenerate

  always_comb begin
    o_index = '0;
    for (int k = 0; k < N; k++) begin
      if (first[k]) begin
        o_index = o_index | W'(k);
      end
    end
  end

  assign o_found = below[N];

endmodule

// ===== rtl/pia_arbiter.sv
`timescale 1ns/1ps
module pia_arbiter
  import pia_pkg::*;
#(
  parameter int NUM_PINS = PIA_NUM_PINS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_nmi,
  input wire logic i_hw_standby,
  input wire logic [NUM_PINS-1:0] i_irq_n,
  input wire logic [PIA_NUM_VEC-1:0] i_periph_req,
  input wire pia_cpu_t i_cpu,
  input wire logic [PIA_ADDR_W-1:0] i_addr,
  input wire logic [PIA_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [PIA_DATA_W-1:0] o_rdata,
  output pia_req_t o_irq
);

  generate
    if (NUM_PINS != int'(PIA_VEC_PIN5 - PIA_VEC_PIN0) + 1) begin : g_bad_pins
      $error("pia_arbiter: pin count must match the pin vector range");
    end
    // The enable bytes and the vector index must span the vector space exactly
    if (PIA_NUM_EN_BYTES * PIA_DATA_W != PIA_NUM_VEC || (1 << PIA_VEC_W) != PIA_NUM_VEC) begin : g_bad_map
      $error("pia_arbiter: enable bytes and vector width must cover the vector space");
    end
  endgenerate

  // Registers
  pia_data_t sysctl_q;
  pia_data_t level_a_q;
  pia_data_t level_b_q;
  logic [PIA_NUM_VEC-1:0] en_q;
  pia_data_t rdata_q;
  pia_data_t rdata_d;

  // Arbitration state
  logic nmi_pend_q;
  logic nmi_prev_q;
  logic valid_q;
  pia_vec_t vec_q;
  logic [15:0] addr_q;

  // Synchronised pins
  logic nmi_s;
  logic stby_s;
  logic [NUM_PINS-1:0] irq_n_s;

  logic [PIA_NUM_VEC-1:0] raw_req;
  logic [PIA_NUM_VEC-1:0] en_req;
  logic [PIA_NUM_VEC-1:0] lvl;
  logic [PIA_NUM_VEC-1:0] hi_req;
  logic [PIA_NUM_VEC-1:0] cand;
  logic sel_found;
  pia_vec_t sel_vec;
  logic sel_ok;
  logic keep_ok;
  logic nmi_edge;
  logic nmi_take;
  logic mode_one;
  logic adv_mode;
  logic mask_glob;
  logic mask_user;
  logic sel_lvl;
  logic held_lvl;

  pia_sync #(
    .WIDTH(2),
    .RST_VAL(1'b0)
  ) u_sync_ctl (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_hw_standby, i_nmi}),
    .o_level({stby_s, nmi_s})
  );

  // Pins idle high, so the pin stages reset to the inactive level
  pia_sync #(
    .WIDTH(NUM_PINS),
    .RST_VAL(1'b1)
  ) u_sync_pins (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_irq_n),
    .o_level(irq_n_s)
  );

  // Both control bits act live: a mode change applies from the next arbitration on
  assign mode_one = sysctl_q[PIA_SYS_MODE_BIT];
  assign adv_mode = sysctl_q[PIA_SYS_ADV_BIT];
  assign mask_glob = i_cpu.mask_global;
  assign mask_user = i_cpu.user_mask_bit;

  // Mask decision for a maskable request of the given level
  function automatic logic unmasked(input logic mode, input logic glob, input logic user, input logic level);
    logic ok;
    if (mode) begin
      ok = ~glob;
    end else if (!level) begin
      ok = ~glob;
    end else begin
      ok = ~(glob & user);
    end
    return ok;
  endfunction

  // Scaled when offered, so a later mode change leaves a standing offer's address alone
  function automatic logic [15:0] vec_addr(input pia_vec_t v, input logic adv);
    logic [15:0] a;
    a = adv ? (16'(v) << PIA_ADV_SHIFT) : (16'(v) << PIA_NORM_SHIFT);
    return a;
  endfunction

  // Pin requests are active-low levels on vectors 12..17; peripherals map by vector number
  generate
    for (genvar v = 0; v < PIA_NUM_VEC; v++) begin : g_vec
      if (v >= int'(PIA_VEC_PIN0) && v <= int'(PIA_VEC_PIN5)) begin : g_pin
        assign raw_req[v] = ~irq_n_s[v - int'(PIA_VEC_PIN0)];
      end else begin : g_per
        // Serial units land on their fixed vectors through this mapping
        assign raw_req[v] = i_periph_req[v];
      end
      assign lvl[v] = pia_level_of(pia_vec_t'(v), level_a_q, level_b_q);
    end
  endgenerate

  // Only mapped sources pass; NMI and reserved vectors are stripped here
  assign en_req = raw_req & en_q & PIA_SRC_MASK;
  // Any level-one request hides every level-zero one before the lowest-index pick
  assign hi_req = en_req & lvl;
  assign cand = (|hi_req) ? hi_req : en_req;

  // Lowest index wins, which is the default order among equal levels
  pia_pick #(
    .N(PIA_NUM_VEC),
    .W(PIA_VEC_W)
  ) u_pick (
    .i_cand(cand),
    .o_found(sel_found),
    .o_index(sel_vec)
  );

  // Selection happens first; a masked winner simply stays pending
  assign sel_lvl = lvl[sel_vec];
  assign sel_ok = sel_found & unmasked(mode_one, mask_glob, mask_user, sel_lvl);
  // A held maskable offer is withdrawn once it would no longer be accepted
  assign held_lvl = lvl[vec_q];
  assign keep_ok = en_req[vec_q] & unmasked(mode_one, mask_glob, mask_user, held_lvl);

  assign nmi_edge = nmi_s & ~nmi_prev_q;
  assign nmi_take = nmi_pend_q & ~stby_s;

  // Starts at the idle low level of the pin, so reset makes no false edge
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      nmi_prev_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_s;
    end
  end

  // NMI latch ignores all masks; a new edge wins over the clear on acceptance
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      nmi_pend_q <= 1'b0;
    end else if (stby_s) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_q <= 1'b1;
    end else if (valid_q && i_cpu.accept && vec_q == PIA_VEC_NMI) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // Offer to the CPU. An NMI offer is held, standby aside, until the CPU reaches an instruction
  // boundary and pulses accept; the CPU then stacks state and raises its own masks.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      valid_q <= 1'b0;
      vec_q <= PIA_VEC_NMI;
      addr_q <= '0;
    end else if (stby_s) begin
      valid_q <= 1'b0;
    end else if (valid_q) begin
      if (i_cpu.accept) begin
        valid_q <= 1'b0;
      end else if (nmi_take && vec_q != PIA_VEC_NMI) begin
        // Not yet taken, so the CPU still sees the highest source
        vec_q <= PIA_VEC_NMI;
        addr_q <= vec_addr(PIA_VEC_NMI, adv_mode);
      end else if (vec_q != PIA_VEC_NMI && !keep_ok) begin
        valid_q <= 1'b0;
      end else begin
        valid_q <= 1'b1;
      end
    // NMI goes ahead of any maskable winner in the same cycle
    end else if (nmi_take) begin
      valid_q <= 1'b1;
      vec_q <= PIA_VEC_NMI;
      addr_q <= vec_addr(PIA_VEC_NMI, adv_mode);
    end else if (sel_ok) begin
      valid_q <= 1'b1;
      vec_q <= sel_vec;
      addr_q <= vec_addr(sel_vec, adv_mode);
    end
  end

  // Every field of the offer comes straight from a flip-flop
  assign o_irq.valid = valid_q;
  assign o_irq.vector = vec_q;
  assign o_irq.addr = addr_q;

  // Register writes
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sysctl_q <= PIA_SYSCTL_RST;
      level_a_q <= PIA_LEVEL_RST;
      level_b_q <= PIA_LEVEL_RST;
    end else if (i_wr) begin
      if (i_addr == PIA_OFF_SYSCTL) begin
        sysctl_q <= i_wdata;
      end
      if (i_addr == PIA_OFF_LEVEL_A) begin
        level_a_q <= i_wdata;
      end
      if (i_addr == PIA_OFF_LEVEL_B) begin
        level_b_q <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      en_q <= {PIA_NUM_EN_BYTES{PIA_EN_RST}};
    end else if (i_wr) begin
      // One byte of enables per address, in vector order
      for (int k = 0; k < PIA_NUM_EN_BYTES; k++) begin
        if (i_addr == pia_addr_t'(int'(PIA_OFF_EN0) + k)) begin
          en_q[k*PIA_DATA_W +: PIA_DATA_W] <= i_wdata;
        end
      end
    end
  end

  // Register reads: data stand in the cycle after the strobe only
  always_comb begin
    rdata_d = '0;
    if (i_rd) begin
      case (i_addr)
        PIA_OFF_SYSCTL: rdata_d = sysctl_q;
        PIA_OFF_LEVEL_A: rdata_d = level_a_q;
        PIA_OFF_LEVEL_B: rdata_d = level_b_q;
        PIA_OFF_STATUS: rdata_d = {valid_q, 1'b0, vec_q};
        PIA_OFF_STATE: rdata_d = pia_data_t'({sel_found, stby_s, nmi_pend_q});
        default: begin
          if (i_addr >= PIA_OFF_EN0 && i_addr < PIA_OFF_STATUS) begin
            rdata_d = en_q[(i_addr - PIA_OFF_EN0) * PIA_DATA_W +: PIA_DATA_W];
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

endmodule

// ===== verif/pia_arbiter_properties.sv
`timescale 1ns/1ps
module pia_arbiter_checker
  import pia_pkg::*;
#(
  parameter int NUM_PINS = PIA_NUM_PINS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_hw_standby,
  input wire logic [NUM_PINS-1:0] i_irq_n,
  input wire pia_cpu_t i_cpu,
  input wire logic [PIA_ADDR_W-1:0] i_addr,
  input wire logic [PIA_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire pia_req_t o_irq
);
  logic [63:0] en_q;
  logic [63:0] en_p;
  logic mode_q;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Shadow of the enable bytes and mode bit, tracked from bus writes
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      en_q <= '0;
      en_p <= '0;
      mode_q <= 1'b1;
    end else begin
      en_p <= en_q;
      if (i_wr && i_addr == PIA_OFF_SYSCTL) mode_q <= i_wdata[PIA_SYS_MODE_BIT];
      if (i_wr && i_addr >= PIA_OFF_EN0 && i_addr < PIA_OFF_STATUS) en_q[8 * int'(i_addr - PIA_OFF_EN0) +: 8] <= i_wdata;
    end
  end
  a_addr_scaled: assert property (
    o_irq.valid |-> o_irq.addr == {8'h00, o_irq.vector, 2'b00} || o_irq.addr == {9'h000, o_irq.vector, 1'b0})
    else $error("vector address not scaled from vector");
  a_vec_legal: assert property (
    o_irq.valid |-> PIA_SRC_MASK[o_irq.vector] || o_irq.vector == PIA_VEC_NMI) else $error("reserved vector offered");
  a_drop_accept: assert property (
    o_irq.valid && i_cpu.accept |=> !o_irq.valid) else $error("offer kept after accept");
  a_standby_blocks: assert property (
    i_hw_standby [*7] |-> !o_irq.valid) else $error("offer during standby");
  a_disabled_ignored: assert property (
    $rose(o_irq.valid) && o_irq.vector != PIA_VEC_NMI |-> en_p[o_irq.vector]) else $error("disabled source offered");
  a_global_only: assert property (
    $rose(o_irq.valid) && $past(mode_q) && $past(i_cpu.mask_global) |-> o_irq.vector == PIA_VEC_NMI)
    else $error("maskable offered under global mask");
  a_both_masks: assert property (
    $rose(o_irq.valid) && $past(i_cpu.mask_global && i_cpu.user_mask_bit) |-> o_irq.vector == PIA_VEC_NMI)
    else $error("maskable offered under both masks");
  a_nmi_holds: assert property (
    (!i_hw_standby) [*6] ##0 (o_irq.valid && o_irq.vector == PIA_VEC_NMI && !i_cpu.accept)
    |=> o_irq.valid && o_irq.vector == PIA_VEC_NMI) else $error("unaccepted NMI offer dropped");
  cover property ($rose(o_irq.valid) && o_irq.vector == PIA_VEC_NMI);
  cover property (o_irq.valid && i_cpu.accept);
  cover property ($rose(o_irq.valid) && !mode_q);
  cover property ($fell(i_irq_n[0]));
endmodule

bind pia_arbiter pia_arbiter_checker #(.NUM_PINS(NUM_PINS)) u_chk (.i_clock(i_clock), .i_rst(i_rst),
  .i_hw_standby(i_hw_standby), .i_irq_n(i_irq_n), .i_cpu(i_cpu), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .o_irq(o_irq));

// ===== verif/pia_cpu_model.sv
`timescale 1ns/1ps
// CPU side: takes an offer after a settable instruction tail, stacks state, raises the global mask (and the user mask in mode 0)
module pia_cpu_model
  import pia_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire pia_req_t i_irq,
  input wire logic i_mode,
  input wire logic i_hold,
  input wire logic [3:0] i_delay,
  input wire logic i_load,
  input wire logic [1:0] i_masks,
  output pia_cpu_t o_cpu,
  output pia_vec_t o_vec,
  output logic [15:0] o_fetch,
  output logic [15:0] o_stack_pc,
  output logic [7:0] o_n_taken
);
  logic [3:0] wait_q;
  logic [15:0] pc_q;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cpu <= 3'h6;
      o_vec <= '0;
      o_fetch <= '0;
      o_stack_pc <= '0;
      o_n_taken <= '0;
      wait_q <= '0;
      pc_q <= '0;
    end else begin
      // Address of the next instruction, which is what a return must resume at
      pc_q <= pc_q + 16'h0002;
      o_cpu.accept <= 1'b0;
      if (i_load) begin
        o_cpu.mask_global <= i_masks[1];
        o_cpu.user_mask_bit <= i_masks[0];
      end
      if (o_cpu.accept && i_irq.valid) begin
        o_stack_pc <= pc_q;
        o_vec <= i_irq.vector;
        o_fetch <= i_irq.addr;
        o_n_taken <= o_n_taken + 8'h01;
        o_cpu.mask_global <= 1'b1;
        o_cpu.user_mask_bit <= i_mode ? o_cpu.user_mask_bit : 1'b1;
        wait_q <= '0;
      end else if (i_irq.valid && !i_hold && !o_cpu.accept) begin
        // A slow tail lets the offer stand for several cycles first
        if (wait_q == i_delay) o_cpu.accept <= 1'b1;
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= '0;
      end
    end
  end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import pia_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_nmi = 1'b0;
  logic i_hw_standby = 1'b0;
  logic [5:0] i_irq_n = 6'h3F;
  logic [63:0] i_periph_req = '0;
  pia_addr_t i_addr = '0;
  pia_data_t i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic mode = 1'b1;
  logic hold = 1'b1;
  logic load = 1'b0;
  logic [3:0] dly = '0;
  logic [1:0] masks = '0;
  pia_cpu_t cpu;
  pia_data_t o_rdata;
  pia_req_t o_irq;
  pia_vec_t t_vec;
  logic [15:0] t_fetch;
  logic [7:0] n_taken;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int w;
  logic [31:0] rng = 32'h0000A738;
  pia_data_t la, lb;
  logic [63:0] rq;
  logic [5:0] pn;
  pia_arbiter #(.NUM_PINS(PIA_NUM_PINS)) dut (.i_clock(i_clock), .i_rst(i_rst), .i_nmi(i_nmi),
    .i_hw_standby(i_hw_standby), .i_irq_n(i_irq_n), .i_periph_req(i_periph_req), .i_cpu(cpu),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
  pia_cpu_model u_cpu (.i_clock(i_clock), .i_rst(i_rst), .i_irq(o_irq), .i_mode(mode), .i_hold(hold),
    .i_delay(dly), .i_load(load), .i_masks(masks), .o_cpu(cpu), .o_vec(t_vec), .o_fetch(t_fetch),
    .o_stack_pc(), .o_n_taken(n_taken));
  always #10 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // Group level of a vector, from the level-bit layout of both level registers
  function automatic logic lvl(int v, pia_data_t a, pia_data_t b);
    case (v) inside
      12: return a[7];
      13: return a[6];
      [14:15]: return a[5];
      [16:17]: return a[4];
      20: return a[3];
      [24:26]: return a[2];
      [28:30]: return a[1];
      [32:34]: return a[0];
      [36:39]: return b[7];
      [40:43]: return b[6];
      [52:55]: return b[3];
      [56:59]: return b[2];
      default: return 1'b0;
    endcase
  endfunction
  function automatic int win(logic [63:0] c, pia_data_t a, pia_data_t b);
    for (int p = 1; p >= 0; p--) begin
      for (int v = 0; v < 64; v++) begin
        if (c[v] && lvl(v, a, b) == p) return v;
      end
    end
    return -1;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wr(pia_addr_t a, pia_data_t d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    tick(1);
    i_wr <= 1'b0;
    tick(1);
  endtask
  task automatic chk_reg(pia_addr_t a, pia_data_t e);
    pia_data_t d;
    i_addr <= a;
    i_rd <= 1'b1;
    tick(1);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
    tick(1);
    `CHK("rdata", e, d)
  endtask
  task automatic lm(logic [1:0] mk);
    masks <= mk;
    load <= 1'b1;
    tick(1);
    load <= 1'b0;
    tick(1);
  endtask
  task automatic setup(logic m, logic adv, logic [1:0] mk);
    mode <= m;
    wr(PIA_OFF_SYSCTL, {6'h00, adv, m});
    lm(mk);
  endtask
  // Lets the CPU model take the standing offer, then compares what it fetched
  task automatic take(pia_vec_t v, int sh);
    logic [7:0] n0;
    n0 = n_taken;
    hold <= 1'b0;
    for (int i = 0; i < 40 && n_taken == n0; i++) tick(1);
    hold <= 1'b1;
    `CHK("vector", v, t_vec)
    `CHK("fetch", 16'(v) << sh, t_fetch)
  endtask
  task automatic note(string s);
    $display("test %s done", s);
  endtask
  initial begin
    tick(2);
    i_rst <= 1'b0;
    tick(1);
    wr(4'hD, 8'hFF);
    chk_reg(PIA_OFF_SYSCTL, PIA_SYSCTL_RST);
    for (int k = 1; k < 16; k++) if (k < 11 || k > 12) chk_reg(pia_addr_t'(k), 8'h00);
    note("reset");
    setup(1'b1, 1'b1, 2'b00);
    i_periph_req <= '1;
    i_irq_n <= 6'h00;
    tick(8);
    `CHK("valid", 1'b0, o_irq.valid)
    for (int k = 0; k < 8; k++) wr(pia_addr_t'(k + 3), ~PIA_SRC_MASK[8 * k +: 8]);
    tick(4);
    `CHK("valid", 1'b0, o_irq.valid)
    i_periph_req <= '0;
    i_irq_n <= 6'h3F;
    for (int k = 0; k < 8; k++) wr(pia_addr_t'(k + 3), 8'hFF);
    note("disabled");
    for (int v = 52; v < 60; v++) begin
      setup(1'b1, v[0], 2'b00);
      dly <= 4'(xs());
      i_periph_req[v] <= 1'b1;
      take(pia_vec_t'(v), v[0] ? 2 : 1);
      i_periph_req[v] <= 1'b0;
      tick(2);
    end
    note("serial");
    for (int k = 0; k < 16; k++) begin
      setup(k[3], 1'b1, k[1:0]);
      wr(PIA_OFF_LEVEL_B, {4'h0, k[2], 3'h0});
      i_periph_req[52] <= 1'b1;
      tick(5);
      `CHK("valid", !k[1] || (!k[3] && k[2] && !k[0]), o_irq.valid)
      i_periph_req[52] <= 1'b0;
      tick(3);
      `CHK("valid", 1'b0, o_irq.valid)
    end
    note("masking");
    for (int n = 0; n < 24; n++) begin
      la = (n == 0) ? 8'h00 : 8'(xs());
      lb = (n == 0) ? 8'hFF : 8'(xs());
      rq = (n == 0) ? '1 : {xs(), xs()};
      pn = 6'(xs());
      setup(1'b1, 1'b1, 2'b10);
      wr(PIA_OFF_LEVEL_A, la);
      wr(PIA_OFF_LEVEL_B, lb);
      i_periph_req <= rq;
      i_irq_n <= pn;
      tick(6);
      lm(2'b00);
      tick(2);
      w = win((rq & PIA_SRC_MASK & ~(64'h3F << 12)) | {46'h0, ~pn, 12'h000}, la, lb);
      `CHK("valid", w >= 0, o_irq.valid)
      if (w >= 0) take(pia_vec_t'(w), 2);
      i_periph_req <= '0;
      i_irq_n <= 6'h3F;
      tick(6);
    end
    note("priority");
    setup(1'b1, 1'b1, 2'b11);
    i_periph_req[20] <= 1'b1;
    i_nmi <= 1'b1;
    tick(8);
    chk_reg(PIA_OFF_STATUS, {2'b10, PIA_VEC_NMI});
    take(PIA_VEC_NMI, 2);
    i_nmi <= 1'b0;
    i_hw_standby <= 1'b1;
    tick(6);
    i_nmi <= 1'b1;
    tick(8);
    `CHK("valid", 1'b0, o_irq.valid)
    chk_reg(PIA_OFF_STATE, 8'h06);
    i_hw_standby <= 1'b0;
    tick(10);
    `CHK("valid", 1'b0, o_irq.valid)
    i_nmi <= 1'b0;
    tick(4);
    i_nmi <= 1'b1;
    tick(8);
    `CHK("valid", 1'b1, o_irq.valid)
    `CHK("vector", PIA_VEC_NMI, o_irq.vector)
    note("nmi");
    complete_run();
  end
endmodule
